// file: ext_bus_ready_waitstate.sv
// Ready-controlled wait-state sequencer for the external bus access phase
// What this block does
// - External circuit stretches or ends each bus cycle
// - Selectable active level of ready input
// - Synchronous mode samples ready directly, shortest cycle
// - Asynchronous mode adds two-flop sync stage, two clocks later
// - Inactive ready inserts another wait state
// - Active ready ends cycle, closing phases follow
// - Async sampling point falls later than sync
// - Ready ignored until mandatory waits elapse
// - Only access phase extends; base 1..32
`timescale 1ns/10ps
module ext_bus_ready_waitstate
  import ready_wait_pkg::*;
#(
  parameter int unsigned WAIT_COUNT_W = 16
)(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bus reference clock tick, one cycle per bus clock unit
  input wire logic bus_reference_clock,
  // Cycle request from the bus controller
  input wire logic cycle_start,
  input wire cycle_cfg_t cycle_cfg,
  // Ready handshake pin
  input wire logic ready_pin,
  // Sequencer outputs
  output logic access_active,
  output logic ready_wait_state,
  output logic cycle_end,
  output logic busy,
  output logic [WAIT_COUNT_W-1:0] wait_count
);

  typedef struct packed {
    seq_state_t fsm;
    cycle_cfg_t cfg;
    logic [5:0] remaining;
    logic [WAIT_COUNT_W-1:0] waits;
    logic done;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;
  logic ready_synced;
  logic ready_raw_active;
  logic ready_sync_active;
  logic ready_seen;
  logic [5:0] access_length;

  ready_sync_stage ready_sync_stage_i (
    .clock(clock),
    .reset(reset),
    .level_in(ready_pin),
    .level_out(ready_synced)
  );

  // polarity applied after synchronisation so stage stays generic
  assign ready_raw_active = ready_pin ^ state.cfg.ready_active_low;
  assign ready_sync_active = ready_synced ^ state.cfg.ready_active_low;

  // async point later by the sync stage delay
  assign ready_seen = state.cfg.ready_async ? ready_sync_active : ready_raw_active;

  // clamp the base length into 1..32
  always_comb begin
    access_length = cycle_cfg.access_length;
    if (cycle_cfg.access_length < 6'(ACCESS_LEN_MIN)) begin
      access_length = 6'(ACCESS_LEN_MIN);
    end else if (cycle_cfg.access_length > 6'(ACCESS_LEN_MAX)) begin
      access_length = 6'(ACCESS_LEN_MAX);
    end
  end

  // Sequencer; access count and ready sampling advance on bus clock ticks only
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    case (state.fsm)
      ST_IDLE: begin
        // latch settings, load the access count and clear the wait counter per cycle
        if (cycle_start) begin
          next_state.cfg = cycle_cfg;
          next_state.cfg.access_length = access_length;
          next_state.remaining = access_length;
          next_state.waits = WAIT_COUNT_RESET[WAIT_COUNT_W-1:0];
          next_state.fsm = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        // mandatory waits run out before ready is looked at
        if (bus_reference_clock) begin
          if (state.remaining > 6'h01) begin
            next_state.remaining = state.remaining - 6'h01;
          end else if (state.cfg.ready_enable) begin
            next_state.fsm = ST_SAMPLE;
          end else begin
            next_state.fsm = ST_CLOSE;
          end
        end
      end
      ST_SAMPLE, ST_READY_WAIT: begin
        if (bus_reference_clock) begin
          if (ready_seen) begin
            next_state.fsm = ST_CLOSE;
          end else begin
            next_state.fsm = ST_READY_WAIT;
            next_state.waits = state.waits + WAIT_COUNT_W'(1);
          end
        end
      end
      ST_CLOSE: begin
        next_state.done = 1'b1;
        next_state.fsm = ST_IDLE;
      end
      default: begin
        next_state.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state.fsm <= ST_IDLE;
      state.cfg <= '0;
      state.remaining <= COUNT_RESET;
      state.waits <= WAIT_COUNT_RESET[WAIT_COUNT_W-1:0];
      state.done <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs
  assign access_active = (state.fsm == ST_ACCESS) || (state.fsm == ST_SAMPLE)
    || (state.fsm == ST_READY_WAIT);
  assign ready_wait_state = (state.fsm == ST_READY_WAIT);
  assign cycle_end = state.done;
  assign busy = (state.fsm != ST_IDLE);
  assign wait_count = state.waits;

  // Assertions
  // Active ready ends the cycle
  a_ready_ends_cycle: assert property (@(posedge clock) disable iff (reset)
    (state.fsm inside {ST_SAMPLE, ST_READY_WAIT}) && bus_reference_clock && ready_seen
    |=> state.fsm == ST_CLOSE ##1 cycle_end)
    else $error("ready did not end the cycle");
  // Inactive ready adds a wait
  a_not_ready_waits: assert property (@(posedge clock) disable iff (reset)
    (state.fsm inside {ST_SAMPLE, ST_READY_WAIT}) && bus_reference_clock && !ready_seen
    |=> ready_wait_state && wait_count == $past(wait_count) + 1'b1)
    else $error("missing ready wait state");
  // No ready look before the access count is done
  a_mandatory_first: assert property (@(posedge clock) disable iff (reset)
    state.fsm == ST_ACCESS && state.remaining > 6'h01 |=> state.fsm == ST_ACCESS)
    else $error("ready considered too early");
  // New cycle clears the wait counter
  a_cycle_clears: assert property (@(posedge clock) disable iff (reset)
    state.fsm == ST_IDLE && cycle_start |=> wait_count == '0 && access_active)
    else $error("cycle start did not reset sequencing");
  // Async ready is the pin two clocks late
  a_async_delay: assert property (@(posedge clock) disable iff (reset)
    state.cfg.ready_async && $stable(state.cfg)
    |-> ready_seen == ($past(ready_pin, 2) ^ state.cfg.ready_active_low))
    else $error("async ready bypassed sync stage");
  // Sync mode closes on the pin itself
  a_sync_direct: assert property (@(posedge clock) disable iff (reset)
    !state.cfg.ready_async && (state.fsm inside {ST_SAMPLE, ST_READY_WAIT})
    && bus_reference_clock && (ready_pin ^ state.cfg.ready_active_low)
    |=> state.fsm == ST_CLOSE)
    else $error("sync ready not direct");
  // Async point lags the pin by the sync stage
  a_async_later: assert property (@(posedge clock) disable iff (reset)
    state.cfg.ready_async && (state.fsm inside {ST_SAMPLE, ST_READY_WAIT})
    && bus_reference_clock && $stable(state.cfg)
    && !($past(ready_pin, 2) ^ state.cfg.ready_active_low) |=> ready_wait_state)
    else $error("async ready sampled too early");
  // Only access is extended, close lasts one cycle
  a_close_single: assert property (@(posedge clock) disable iff (reset)
    state.fsm == ST_CLOSE |=> state.fsm == ST_IDLE && !access_active)
    else $error("closing phase stretched");
  // Latched length stays in range
  a_length_range: assert property (@(posedge clock) disable iff (reset)
    busy |-> state.cfg.access_length >= 6'(ACCESS_LEN_MIN)
    && state.cfg.access_length <= 6'(ACCESS_LEN_MAX))
    else $error("access length out of range");
  // Each tick before the last shortens the base length by one
  a_access_counts: assert property (@(posedge clock) disable iff (reset)
    state.fsm == ST_ACCESS && bus_reference_clock && state.remaining > 6'h01
    |=> state.remaining == $past(state.remaining) - 6'h01)
    else $error("access length not counted per tick");
  // Start while busy must not disturb the latched settings
  a_refused_start: assert property (@(posedge clock) disable iff (reset)
    busy && cycle_start |=> $stable(state.cfg))
    else $error("start accepted while busy");
  // End pulse lasts one clock with busy already low
  a_end_pulse: assert property (@(posedge clock) disable iff (reset)
    cycle_end |-> !busy ##1 !cycle_end)
    else $error("end pulse malformed");
  // Ready waits only when ready control is on
  a_wait_needs_enable: assert property (@(posedge clock) disable iff (reset)
    ready_wait_state |-> state.cfg.ready_enable)
    else $error("ready wait without ready control");
  // Idle shows no phase
  a_idle_quiet: assert property (@(posedge clock) disable iff (reset)
    !busy |-> !access_active && !ready_wait_state)
    else $error("phase flag while idle");
  // Without a reference tick ready sampling and waits do not advance
  a_tick_paced: assert property (@(posedge clock) disable iff (reset)
    (state.fsm inside {ST_SAMPLE, ST_READY_WAIT}) && !bus_reference_clock
    |=> $stable(state.fsm) && $stable(wait_count))
    else $error("ready sampled off the reference tick");

  // Main scenarios
  c_slow_tick: cover property (@(posedge clock) disable iff (reset)
    state.fsm == ST_READY_WAIT && !bus_reference_clock);
  c_sync_cycle: cover property (@(posedge clock) disable iff (reset)
    !state.cfg.ready_async && state.fsm == ST_CLOSE);
  c_async_cycle: cover property (@(posedge clock) disable iff (reset)
    state.cfg.ready_async && state.fsm == ST_CLOSE);
  c_many_waits: cover property (@(posedge clock) disable iff (reset)
    ready_wait_state && wait_count == 16'h0003);
  c_no_ready: cover property (@(posedge clock) disable iff (reset)
    !state.cfg.ready_enable && cycle_end);

endmodule

// file: ext_bus_ready_waitstate_tb.sv
// Self-checking bench for the ready wait-state sequencer
`timescale 1ns/10ps
module ext_bus_ready_waitstate_tb;
  import ready_wait_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic bus_reference_clock = 1'b1; // Tick every clock unless slow_ref
  logic slow_ref = 1'b0;
  int last_len = 0;
  logic cycle_start = 1'b0;
  cycle_cfg_t cycle_cfg = '0;
  logic ready_pin;
  logic access_active, ready_wait_state, cycle_end, busy;
  logic [15:0] wait_count;
  logic lo = 1'b0;
  logic [5:0] dly = 6'h00;
  int err_total = 0;
  int num_checks = 0;

  ext_bus_ready_waitstate ext_bus_ready_waitstate_i (.clock(clock), .reset(reset),
    .bus_reference_clock(bus_reference_clock), .cycle_start(cycle_start),
    .cycle_cfg(cycle_cfg), .ready_pin(ready_pin), .access_active(access_active),
    .ready_wait_state(ready_wait_state), .cycle_end(cycle_end), .busy(busy),
    .wait_count(wait_count));
  ready_target_model ready_target_model_i (.clock(clock), .reset(reset), .active_low(lo),
    .delay_ticks(dly), .bus_reference_clock(bus_reference_clock),
    .access_active(access_active), .ready_pin(ready_pin));

  // Free-running 50 MHz clock
  initial begin
    forever #10 clock = ~clock;
  end

  // Reference tick every second clock while slow_ref is set
  always @(posedge clock) begin
    bus_reference_clock <= slow_ref ? ~bus_reference_clock : 1'b1;
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Config is scrambled after the start edge, so only the latched copy counts
  task automatic run_cycle(input cycle_cfg_t c, input logic [5:0] d, input logic extra,
      input logic [15:0] e);
    int n;
    logic seen;
    seen = 1'b0;
    lo <= c.ready_active_low;
    dly <= d;
    cycle_start <= 1'b1;
    cycle_cfg <= c;
    @(posedge clock);
    cycle_start <= 1'b0;
    cycle_cfg <= ~c;
    @(posedge clock);
    check_val({14'h0000, busy, access_active}, 16'h0003);
    cycle_start <= extra; // Second start while busy
    @(posedge clock);
    cycle_start <= 1'b0;
    for (n = 0; n < 300 && cycle_end !== 1'b1; n++) begin
      if (ready_wait_state === 1'b1) seen = 1'b1;
      @(posedge clock);
    end
    last_len = n;
    if (n == 300) begin
      err_total++;
      tally_and_finish();
    end else begin
      check_val(wait_count, e);
      check_val({15'h0000, seen}, {15'h0000, e != 16'h0000});
      check_val({15'h0000, access_active}, 16'h0000);
      @(posedge clock);
      check_val({15'h0000, cycle_end}, 16'h0000);
      repeat (3) @(posedge clock);
      check_val({15'h0000, busy}, 16'h0000);
    end
  endtask

  task automatic sc_sync();
    run_cycle('{1'b0, 1'b0, 1'b1, 6'h01}, 6'h00, 1'b0, 16'h0000);
    check_val(16'(last_len), 16'h0002);
    run_cycle('{1'b0, 1'b0, 1'b1, 6'h02}, 6'h05, 1'b0, 16'h0003);
  endtask

  // Two synchroniser flops push the usable sample two clocks later
  task automatic sc_async();
    run_cycle('{1'b0, 1'b1, 1'b1, 6'h02}, 6'h02, 1'b0, 16'h0002);
    run_cycle('{1'b0, 1'b1, 1'b1, 6'h01}, 6'h04, 1'b0, 16'h0005);
  endtask

  task automatic sc_polarity();
    run_cycle('{1'b1, 1'b0, 1'b1, 6'h01}, 6'h03, 1'b0, 16'h0002);
  endtask

  task automatic sc_length();
    run_cycle('{1'b0, 1'b0, 1'b1, 6'h20}, 6'h22, 1'b0, 16'h0002);
    run_cycle('{1'b0, 1'b0, 1'b1, 6'h00}, 6'h03, 1'b0, 16'h0002);
  endtask

  task automatic sc_no_ready();
    run_cycle('{1'b0, 1'b0, 1'b0, 6'h03}, 6'h09, 1'b0, 16'h0000);
  endtask

  task automatic sc_refuse();
    run_cycle('{1'b0, 1'b0, 1'b1, 6'h08}, 6'h08, 1'b1, 16'h0000);
    check_val(16'(last_len), 16'h0009);
  endtask

  // Reset in the middle of ready waits must clear all sequencing
  task automatic sc_reset();
    lo <= 1'b0;
    dly <= 6'h3F;
    cycle_cfg <= '{1'b0, 1'b0, 1'b1, 6'h01};
    cycle_start <= 1'b1;
    @(posedge clock);
    cycle_start <= 1'b0;
    repeat (4) @(posedge clock);
    check_val(wait_count, 16'h0002);
    check_val({15'h0000, busy}, 16'h0001);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check_val({13'h0000, busy, access_active, cycle_end}, 16'h0000);
    check_val(wait_count, 16'h0000);
    run_cycle('{1'b0, 1'b0, 1'b1, 6'h01}, 6'h02, 1'b0, 16'h0001);
  endtask

  // Reference tick only every second clock
  task automatic sc_slow_ref();
    slow_ref <= 1'b1;
    run_cycle('{1'b0, 1'b0, 1'b1, 6'h02}, 6'h04, 1'b0, 16'h0002);
    run_cycle('{1'b0, 1'b1, 1'b1, 6'h01}, 6'h01, 1'b0, 16'h0001);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    sc_sync();
    sc_async();
    sc_polarity();
    sc_length();
    sc_no_ready();
    sc_refuse();
    sc_reset();
    sc_slow_ref();
    tally_and_finish();
  end
endmodule

// file: ready_sync_stage.sv
// Extra synchronisation stage for the asynchronous ready input
`timescale 1ns/10ps
module ready_sync_stage
  import ready_wait_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Raw and synchronised level
  input wire logic level_in,
  output logic level_out
);

  typedef struct packed {
    logic first;
    logic second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // First stage feeds only the second
  always_comb begin
    next_state = state;
    next_state.first = level_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_out = state.second;

endmodule

// file: ready_target_model.sv
// Behavioural external memory answering with a ready handshake
`timescale 1ns/10ps
module ready_target_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Answer settings from the bench
  input wire logic active_low,
  input wire logic [5:0] delay_ticks,
  // Bus side
  input wire logic bus_reference_clock,
  input wire logic access_active,
  output logic ready_pin
);
  logic [5:0] ticks;
  // count reference ticks of the access
  always_ff @(posedge clock) begin
    if (reset || !access_active) begin
      ticks <= 6'h00;
    end else if (bus_reference_clock && ticks != 6'h3F) begin
      ticks <= ticks + 6'h01; // Saturates, never wraps
    end
  end
  // held until access ends, gone before next sample
  assign ready_pin = (access_active && ticks >= delay_ticks) ^ active_low;
endmodule

// file: ready_wait_pkg.sv
// Package for the ready-controlled wait-state sequencer
package ready_wait_pkg;

  // Access phase base length limits, in bus clock units
  localparam int unsigned ACCESS_LEN_MIN = 1;
  localparam int unsigned ACCESS_LEN_MAX = 32;
  localparam int unsigned ACCESS_LEN_W = 6;

  // Mandatory wait states before ready is considered
  localparam logic [5:0] MANDATORY_WAIT_DEFAULT = 6'h01;

  // Reset values
  localparam logic [5:0] COUNT_RESET = 6'h00;
  localparam logic [15:0] WAIT_COUNT_RESET = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACCESS = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_READY_WAIT = 3'b011,
    ST_CLOSE = 3'b100
  } seq_state_t;

  // Per-cycle configuration, latched at cycle start
  typedef struct packed {
    logic ready_active_low;
    logic ready_async;
    logic ready_enable;
    logic [5:0] access_length;
  } cycle_cfg_t;

  // Status shown to the bus controller
  typedef struct packed {
    logic busy;
    logic access_phase;
    logic ready_wait;
    logic cycle_done;
  } seq_status_t;

endpackage
